/* hw/amc_area_match.sv */
// Finds the lowest-numbered area whose range holds an address.
// Assumes area ranges come from flip-flops on the same clock.
module amc_area_match (
    // Address under test
    input  wire logic [amc_pkg::ADDR_W-1:0]                     addr,
    // Area table
    input  wire logic [amc_pkg::AREAS-1:0][amc_pkg::ADDR_W-1:0] area_base,
    input  wire logic [amc_pkg::AREAS-1:0][amc_pkg::ADDR_W-1:0] area_last,
    // Result
    output logic                                                hit,
    output logic      [amc_pkg::IDX_W-1:0]                      idx
);

    logic [amc_pkg::AREAS-1:0] in_area;

    genvar g;
    generate
        for (g = 0; g < amc_pkg::AREAS; g++) begin : g_cmp
            assign in_area[g] = (addr >= area_base[g]) && (addr <= area_last[g]);
        end
    endgenerate

    // Lowest index wins
    always_comb begin
        hit = 1'b0;
        idx = '0;
        for (int i = amc_pkg::AREAS - 1; i >= 0; i--) begin
            if (in_area[i]) begin
                hit = 1'b1;
                idx = amc_pkg::IDX_W'(i);
            end
        end
    end

endmodule // amc_area_match

/* hw/amc_checker.sv */
// Area based memory access checker between core and ROM, RAM and flash.
// Assumes the core drives requests and configuration on mclk with no sync.
module amc_checker (
    // Clock, reset, enable
    input  wire logic                         mclk,
    input  wire logic                         sys_rst,
    input  wire logic                         ce,
    // Access request from core
    input  wire logic                         req_valid,
    input  wire logic [amc_pkg::ADDR_W-1:0]   req_addr,
    input  wire logic [amc_pkg::ADDR_W-1:0]   req_pc,
    input  wire logic [1:0]                   req_op,
    input  wire logic                         req_priv,
    // Decision
    output logic                              req_grant,
    output logic                              req_deny,
    // Memory strobes
    output logic                              rom_en,
    output logic                              ram_en,
    output logic                              flash_en,
    output logic                              mem_we,
    // Configuration port
    input  wire logic                         cfg_valid,
    input  wire logic [2:0]                   cfg_cmd,
    input  wire logic [amc_pkg::IDX_W-1:0]    cfg_idx,
    input  wire logic [amc_pkg::ADDR_W-1:0]   cfg_base,
    input  wire logic [amc_pkg::ADDR_W-1:0]   cfg_last,
    input  wire logic [amc_pkg::ATTR_W-1:0]   cfg_attr,
    input  wire logic [amc_pkg::AREAS-1:0]    cfg_code,
    input  wire logic                         cfg_priv,
    output logic                              cfg_ignored,
    // Violation report
    input  wire logic                         viol_clr,
    output logic                              viol_pulse,
    output logic                              viol_flag,
    output logic      [amc_pkg::ADDR_W-1:0]   viol_addr,
    output logic      [1:0]                   viol_op,
    output logic                              viol_priv
);

    localparam int N = amc_pkg::AREAS;

    // Live, staged and initial tables
    logic [N-1:0][amc_pkg::ADDR_W-1:0] live_base,  stg_base,  ini_base;
    logic [N-1:0][amc_pkg::ADDR_W-1:0] live_last,  stg_last,  ini_last;
    logic [N-1:0][amc_pkg::ATTR_W-1:0] live_attr,  stg_attr,  ini_attr;
    logic [N-1:0][N-1:0]               live_code,  stg_code,  ini_code;

    // Memory window decode
    function automatic logic [2:0] mem_of(input logic [amc_pkg::ADDR_W-1:0] a);
        logic [2:0] m;
        m = amc_pkg::AMC_MEM_NONE;
        if (a >= amc_pkg::ROM_BASE && a <= amc_pkg::ROM_LAST)
            m = amc_pkg::AMC_MEM_ROM;
        else if (a >= amc_pkg::RAM_BASE && a <= amc_pkg::RAM_LAST)
            m = amc_pkg::AMC_MEM_RAM;
        else if (a >= amc_pkg::FLASH_BASE && a <= amc_pkg::FLASH_LAST)
            m = amc_pkg::AMC_MEM_FLASH;
        return m;
    endfunction

    // Area lookups
    logic                     tgt_hit, code_hit;
    logic [amc_pkg::IDX_W-1:0] tgt_idx, code_idx;

    amc_area_match u_tgt_match (
        .addr      (req_addr),
        .area_base (live_base),
        .area_last (live_last),
        .hit       (tgt_hit),
        .idx       (tgt_idx)
    );

    amc_area_match u_code_match (
        .addr      (req_pc),
        .area_base (live_base),
        .area_last (live_last),
        .hit       (code_hit),
        .idx       (code_idx)
    );

    // Permission decision
    wire [amc_pkg::ATTR_W-1:0] tgt_attr  = tgt_hit ? live_attr[tgt_idx]
                                                   : amc_pkg::MISS_ATTR;
    wire [N-1:0]               tgt_code  = tgt_hit ? live_code[tgt_idx] : {N{1'b1}};
    wire                       code_ok   = req_priv || !code_hit || tgt_code[code_idx];
    wire is_rd = (req_op == amc_pkg::AMC_OP_READ);
    wire is_wr = (req_op == amc_pkg::AMC_OP_WRITE);
    wire is_ex = (req_op == amc_pkg::AMC_OP_EXEC);
    wire op_ok = req_priv ?
        ((is_rd && tgt_attr[amc_pkg::ATTR_PR]) || (is_wr && tgt_attr[amc_pkg::ATTR_PW]) ||
         (is_ex && tgt_attr[amc_pkg::ATTR_PX])) :
        ((is_rd && tgt_attr[amc_pkg::ATTR_UR]) || (is_wr && tgt_attr[amc_pkg::ATTR_UW]) ||
         (is_ex && tgt_attr[amc_pkg::ATTR_UX]));
    wire [2:0] tgt_mem = mem_of(req_addr);
    wire permit = op_ok && code_ok && (tgt_mem != amc_pkg::AMC_MEM_NONE);

    assign req_grant = req_valid && permit;
    assign req_deny  = req_valid && !permit;
    assign rom_en    = req_grant && tgt_mem[0];
    assign ram_en    = req_grant && tgt_mem[1];
    assign flash_en  = req_grant && tgt_mem[2];
    assign mem_we    = req_grant && is_wr;

    // Configuration command decode
    wire cfg_take    = cfg_valid && cfg_priv;
    wire do_stage    = cfg_take && (cfg_cmd == amc_pkg::AMC_CMD_STAGE);
    wire do_accept   = cfg_take && (cfg_cmd == amc_pkg::AMC_CMD_ACCEPT);
    wire do_init     = cfg_take && (cfg_cmd == amc_pkg::AMC_CMD_INIT);
    wire do_restore  = cfg_take && (cfg_cmd == amc_pkg::AMC_CMD_RESTORE);
    wire cfg_refused = cfg_valid && !cfg_priv;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_area
            wire sel = (cfg_idx == amc_pkg::IDX_W'(g));
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    live_base[g] <= amc_pkg::DEF_BASE;
                    live_last[g] <= amc_pkg::DEF_LAST;
                    live_attr[g] <= amc_pkg::DEF_ATTR;
                    live_code[g] <= amc_pkg::DEF_CODE;
                end else if (ce) begin
                    if (do_accept) begin
                        live_base[g] <= stg_base[g];
                        live_last[g] <= stg_last[g];
                        live_attr[g] <= stg_attr[g];
                        live_code[g] <= stg_code[g];
                    end else if (do_restore && sel) begin
                        live_base[g] <= ini_base[g];
                        live_last[g] <= ini_last[g];
                        live_attr[g] <= ini_attr[g];
                        live_code[g] <= ini_code[g];
                    end
                end
            end
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    stg_base[g] <= amc_pkg::DEF_BASE;
                    stg_last[g] <= amc_pkg::DEF_LAST;
                    stg_attr[g] <= amc_pkg::DEF_ATTR;
                    stg_code[g] <= amc_pkg::DEF_CODE;
                end else if (ce) begin
                    if (do_stage && sel) begin
                        stg_base[g] <= cfg_base;
                        stg_last[g] <= cfg_last;
                        stg_attr[g] <= cfg_attr;
                        stg_code[g] <= cfg_code;
                    end else if (do_restore && sel) begin
                        stg_base[g] <= ini_base[g];
                        stg_last[g] <= ini_last[g];
                        stg_attr[g] <= ini_attr[g];
                        stg_code[g] <= ini_code[g];
                    end
                end
            end
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    ini_base[g] <= amc_pkg::DEF_BASE;
                    ini_last[g] <= amc_pkg::DEF_LAST;
                    ini_attr[g] <= amc_pkg::DEF_ATTR;
                    ini_code[g] <= amc_pkg::DEF_CODE;
                end else if (ce && do_init && sel) begin
                    ini_base[g] <= cfg_base;
                    ini_last[g] <= cfg_last;
                    ini_attr[g] <= cfg_attr;
                    ini_code[g] <= cfg_code;
                end
            end
        end
    endgenerate

    // Refused configuration indication
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfg_ignored <= 1'b0;
        end else if (ce) begin
            cfg_ignored <= cfg_refused;
        end
    end

    // Violation report
    wire viol_wipe = viol_clr && cfg_priv;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            viol_pulse <= 1'b0;
            viol_flag  <= 1'b0;
        end else if (ce) begin
            viol_pulse <= req_deny;
            if (req_deny) begin
                viol_flag <= 1'b1;
            end else if (viol_wipe) begin
                viol_flag <= 1'b0;
            end
        end
    end

    // Violation details
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            viol_addr <= '0;
            viol_op   <= '0;
            viol_priv <= 1'b0;
        end else if (ce && req_deny) begin
            viol_addr <= req_addr;
            viol_op   <= req_op;
            viol_priv <= req_priv;
        end
    end

endmodule // amc_checker

/* hw/amc_pkg.sv */
// Shared constants and types for the area memory access checker.
// Assumes a single 200 MHz clock domain and a synchronous active-high reset.
package amc_pkg;

    localparam int AREAS    = 8;
    localparam int IDX_W    = 3;
    localparam int ADDR_W   = 32;
    localparam int ATTR_W   = 6;

    // Attribute bit positions
    localparam int ATTR_UR  = 0;
    localparam int ATTR_UW  = 1;
    localparam int ATTR_UX  = 2;
    localparam int ATTR_PR  = 3;
    localparam int ATTR_PW  = 4;
    localparam int ATTR_PX  = 5;

    // On-chip memory windows
    localparam logic [ADDR_W-1:0] ROM_BASE   = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] ROM_LAST   = 32'h0003_FFFF;
    localparam logic [ADDR_W-1:0] RAM_BASE   = 32'h2000_0000;
    localparam logic [ADDR_W-1:0] RAM_LAST   = 32'h2000_FFFF;
    localparam logic [ADDR_W-1:0] FLASH_BASE = 32'h0800_0000;
    localparam logic [ADDR_W-1:0] FLASH_LAST = 32'h080F_FFFF;

    // Manufacturing defaults, one entry for all areas
    localparam logic [ADDR_W-1:0] DEF_BASE  = 32'hFFFF_FFFF;
    localparam logic [ADDR_W-1:0] DEF_LAST  = 32'h0000_0000;
    localparam logic [ATTR_W-1:0] DEF_ATTR  = 6'h38;
    localparam logic [AREAS-1:0]  DEF_CODE  = 8'hFF;
    // Attributes used where no area matches
    localparam logic [ATTR_W-1:0] MISS_ATTR = 6'h38;

    typedef enum logic [1:0] {
        AMC_OP_READ  = 2'h0,
        AMC_OP_WRITE = 2'h1,
        AMC_OP_EXEC  = 2'h2
    } amc_op_t;

    typedef enum logic [2:0] {
        AMC_CMD_STAGE   = 3'h0,
        AMC_CMD_ACCEPT  = 3'h1,
        AMC_CMD_INIT    = 3'h2,
        AMC_CMD_RESTORE = 3'h3
    } amc_cmd_t;

    typedef enum logic [2:0] {
        AMC_MEM_NONE  = 3'h0,
        AMC_MEM_ROM   = 3'h1,
        AMC_MEM_RAM   = 3'h2,
        AMC_MEM_FLASH = 3'h4
    } amc_mem_t;

endpackage

/* verification/amc_checker_sva_checker.sv */
// Port assertions for the area memory access checker.
// Assumes one mclk domain with synchronous active-high sys_rst.
module amc_checker_sva (
    // Clock, reset, enable
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        ce,
    // Access side
    input wire logic        req_valid,
    input wire logic [31:0] req_addr,
    input wire logic [1:0]  req_op,
    input wire logic        req_priv,
    input wire logic        req_grant,
    input wire logic        req_deny,
    input wire logic        rom_en,
    input wire logic        ram_en,
    input wire logic        flash_en,
    input wire logic        mem_we,
    // Configuration and report
    input wire logic        cfg_valid,
    input wire logic        cfg_priv,
    input wire logic        cfg_ignored,
    input wire logic        viol_pulse,
    input wire logic        viol_flag,
    input wire logic [31:0] viol_addr,
    input wire logic [1:0]  viol_op,
    input wire logic        viol_priv
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire logic any_en = rom_en | ram_en | flash_en;
    sequence s_deny;
        ce && req_deny;
    endsequence
    sequence s_report;
        viol_pulse && viol_flag;
    endsequence
    AST_DENY_QUIET: assert property (req_deny |-> !any_en && !mem_we)
        else $error("memory strobe on a denied access");
    AST_WRITE_ONLY: assert property (mem_we |-> req_grant && req_op == 2'h1)
        else $error("write strobe without granted write");
    AST_ONE_ANSWER: assert property (req_valid |-> req_grant != req_deny)
        else $error("access without exactly one answer");
    AST_NO_REQ: assert property (!req_valid |-> !req_grant && !req_deny)
        else $error("answer without a request");
    AST_GRANT_WIN: assert property (req_grant |-> $onehot({rom_en, ram_en, flash_en}))
        else $error("grant without one memory window");
    AST_BAD_OP: assert property (req_valid && req_op == 2'h3 |-> req_deny)
        else $error("undefined operation not denied");
    AST_REPORT: assert property (s_deny |=> s_report ##0 viol_addr == $past(req_addr))
        else $error("deny not reported with its address");
    AST_REPORT_KIND: assert property (s_deny |=> viol_op == $past(req_op)
        && viol_priv == $past(req_priv))
        else $error("deny reported with wrong kind");
    AST_NO_VIOL: assert property (ce && !req_deny |=> !viol_pulse)
        else $error("violation pulse without a deny");
    AST_USER_CFG: assert property (ce && cfg_valid && !cfg_priv |=> cfg_ignored)
        else $error("user command not flagged as ignored");
    AST_PRIV_CFG: assert property (ce && !(cfg_valid && !cfg_priv) |=> !cfg_ignored)
        else $error("ignored flag without a user command");
    AST_CE_FREEZE: assert property (!ce |=> $stable(viol_pulse) && $stable(viol_flag)
        && $stable(viol_addr) && $stable(cfg_ignored))
        else $error("report state changed with clock enable low");
endmodule // amc_checker_sva

bind amc_checker amc_checker_sva amc_checker_sva_i (
    .mclk, .sys_rst, .ce, .req_valid, .req_addr, .req_op, .req_priv, .req_grant,
    .req_deny, .rom_en, .ram_en, .flash_en, .mem_we, .cfg_valid, .cfg_priv,
    .cfg_ignored, .viol_pulse, .viol_flag, .viol_addr, .viol_op, .viol_priv
);

/* verification/amc_checker_tb.sv */
// Self-checking bench for the area memory access checker.
// Assumes the package, design, assertions and memory model compile first.
module amc_checker_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] NO = 3'h0, ROM = amc_pkg::AMC_MEM_ROM;
    localparam logic [2:0] RAM = amc_pkg::AMC_MEM_RAM, FL = amc_pkg::AMC_MEM_FLASH;
    localparam logic [2:0] STG = 3'h0, ACC = 3'h1, INI = 3'h2, RES = 3'h3;
    logic        mclk, sys_rst, ce, req_valid, req_priv, req_grant, req_deny;
    logic        rom_en, ram_en, flash_en, mem_we, cfg_valid, cfg_priv;
    logic        cfg_ignored, viol_clr, viol_pulse, viol_flag, viol_priv, p;
    logic [31:0] req_addr, req_pc, cfg_base, cfg_last, viol_addr, a;
    logic [1:0]  req_op, viol_op, op;
    logic [2:0]  cfg_cmd, cfg_idx;
    logic [5:0]  cfg_attr, e;
    logic [7:0]  cfg_code;
    logic [15:0] rd_cnt, wr_cnt, exp_rd, exp_wr;
    logic [5:0]  expq[$];
    int          num_errors, compares, seed;
    amc_checker amc_checker_i (
        .mclk, .sys_rst, .ce, .req_valid, .req_addr, .req_pc, .req_op, .req_priv,
        .req_grant, .req_deny, .rom_en, .ram_en, .flash_en, .mem_we, .cfg_valid,
        .cfg_cmd, .cfg_idx, .cfg_base, .cfg_last, .cfg_attr, .cfg_code, .cfg_priv,
        .cfg_ignored, .viol_clr, .viol_pulse, .viol_flag, .viol_addr, .viol_op, .viol_priv
    );
    amc_mem_model amc_mem_model_i (
        .mclk, .sys_rst, .rom_en, .ram_en, .flash_en, .mem_we, .rd_cnt, .wr_cnt
    );
    always #2.5 mclk = ~mclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic acc(input logic [31:0] ad, pc, input logic [1:0] o, input logic pv,
                       input logic [2:0] m);
        @(posedge mclk);
        req_valid <= 1'b1;
        cfg_valid <= 1'b0;
        req_addr <= ad;
        req_pc <= pc;
        req_op <= o;
        req_priv <= pv;
        expq.push_back({|m, ~|m, m, (|m) && o == 2'h1});
        if (|m && o == 2'h1) exp_wr++;
        else if (|m) exp_rd++;
    endtask
    task automatic cfg(input logic [2:0] c, i, input logic [31:0] b, l,
                       input logic [5:0] at, input logic [7:0] cd, input logic pv);
        @(posedge mclk);
        req_valid <= 1'b0;
        cfg_valid <= 1'b1;
        cfg_cmd <= c;
        cfg_idx <= i;
        cfg_base <= b;
        cfg_last <= l;
        cfg_attr <= at;
        cfg_code <= cd;
        cfg_priv <= pv;
    endtask
    task automatic step(input int n);
        @(posedge mclk);
        req_valid <= 1'b0;
        cfg_valid <= 1'b0;
        $display("test %0d done", n);
    endtask
    task automatic print_verdict;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(negedge mclk) begin
        if (req_valid === 1'b1) begin
            e = expq.pop_front();
            chk({req_grant, req_deny, flash_en, ram_en, rom_en, mem_we}, e);
        end
    end
    initial begin
        #20000;
        num_errors++;
        print_verdict;
    end
    initial begin
        {mclk, req_valid, cfg_valid, viol_clr, req_priv, cfg_priv} = '0;
        {sys_rst, ce} = 2'h3;
        {req_addr, req_pc, cfg_base, cfg_last, req_op, cfg_cmd, cfg_idx} = '0;
        {cfg_attr, cfg_code, exp_rd, exp_wr, num_errors, compares} = '0;
        seed = 32'h3826;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        acc(32'h100, 0, 2'h0, 1, ROM);
        acc(32'h2000_0010, 0, 2'h1, 1, RAM);
        acc(32'h0800_0000, 0, 2'h2, 1, FL);
        acc(32'h100, 0, 2'h0, 0, NO);
        acc(32'h4000_0000, 0, 2'h0, 1, NO);
        acc(32'h100, 0, 2'h3, 1, NO);
        step(1);
        viol_clr <= 1'b1;
        cfg_priv <= 1'b1;
        @(negedge mclk);
        chk(viol_flag, 1'b1);
        chk(viol_addr, 32'h100);
        chk({viol_op, viol_priv}, 3'h7);
        @(posedge mclk);
        viol_clr <= 1'b0;
        @(negedge mclk);
        chk(viol_flag, 1'b0);
        cfg(STG, 0, 32'h2000_0000, 32'h2000_0FFF, 6'h03, 8'hFF, 1);
        acc(32'h2000_0010, 0, 2'h1, 0, NO);
        cfg(ACC, 0, 0, 0, 0, 0, 1);
        acc(32'h2000_0010, 0, 2'h1, 0, RAM);
        acc(32'h2000_0FFF, 0, 2'h0, 0, RAM);
        acc(32'h2000_1000, 0, 2'h0, 0, NO);
        acc(32'h2000_0010, 0, 2'h2, 0, NO);
        step(2);
        cfg(STG, 0, 32'h2000_0000, 32'h2000_0FFF, 6'h00, 8'hFF, 0);
        cfg(ACC, 0, 0, 0, 0, 0, 0);
        @(negedge mclk);
        chk(cfg_ignored, 1'b1);
        acc(32'h2000_0010, 0, 2'h0, 0, RAM);
        step(3);
        cfg(STG, 1, 32'h0800_0000, 32'h080F_FFFF, 6'h05, 8'h02, 1);
        cfg(ACC, 0, 0, 0, 0, 0, 1);
        acc(32'h0800_0100, 32'h2000_0010, 2'h0, 0, NO);
        acc(32'h0800_0100, 32'h0800_0000, 2'h0, 0, FL);
        acc(32'h0800_0100, 32'h100, 2'h2, 0, FL);
        step(4);
        cfg(INI, 2, 0, 32'h0003_FFFF, 6'h01, 8'hFF, 1);
        acc(32'h200, 0, 2'h0, 0, NO);
        cfg(RES, 2, 0, 0, 0, 0, 1);
        acc(32'h200, 0, 2'h0, 0, ROM);
        step(5);
        repeat (16) begin
            a = 32'h2000_0000 | ($random(seed) & 32'h1FFF);
            op = $random(seed) & 2'h1;
            p = $random(seed) & 1'b1;
            acc(a, 0, op, p, ((a < 32'h2000_1000) ? !p : p) ? RAM : NO);
        end
        step(6);
        @(posedge mclk);
        ce <= 1'b0;
        cfg(STG, 0, 32'h2000_0000, 32'h2000_0FFF, 6'h00, 8'hFF, 1);
        cfg(ACC, 0, 0, 0, 0, 0, 1);
        acc(32'h100, 0, 2'h2, 0, NO);
        step(7);
        ce <= 1'b1;
        @(negedge mclk);
        chk(viol_pulse, 1'b0);
        acc(32'h2000_0010, 0, 2'h1, 0, RAM);
        step(8);
        @(negedge mclk);
        chk(rd_cnt, exp_rd);
        chk(wr_cnt, exp_wr);
        print_verdict;
    end
endmodule // amc_checker_tb

/* verification/amc_mem_model.sv */
// Memory side model counting read and write strobes.
// Assumes each granted access strobes for one mclk cycle.
module amc_mem_model (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        sys_rst,
    // Memory strobes
    input wire logic        rom_en,
    input wire logic        ram_en,
    input wire logic        flash_en,
    input wire logic        mem_we,
    // Counts
    output logic     [15:0] rd_cnt,
    output logic     [15:0] wr_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge mclk) begin
        if (sys_rst) begin
            rd_cnt <= 16'h0;
            wr_cnt <= 16'h0;
        end else begin
            if ((rom_en | ram_en | flash_en) && !mem_we) rd_cnt <= rd_cnt + 16'h1;
            if (mem_we) wr_cnt <= wr_cnt + 16'h1;
        end
    end
endmodule // amc_mem_model
